// File: flash_op_pkg.sv
// Purpose: Shared constants and types of the flash write-operation command register
// Assumes: 16-bit register, 24-bit flash addresses
// Notes:   Bit positions and ranges are named here once
package flash_op_pkg;
    localparam int          ADDR_W        = 24;
    localparam logic [23:0] CMD_OFFSET    = 24'h0e0002;
    localparam logic [15:0] CMD_RESET     = 16'h0000;
    // Launch, suspend, four selections and module select; others reserved
    localparam logic [15:0] CMD_WRITABLE  = 16'hf980;
    localparam logic [15:0] CMD_SEL_MASK  = 16'h3980;
    localparam int          LAUNCH_POS    = 15;
    localparam int          SUSPEND_BIT_POS      = 14;
    localparam int          WPG_POS       = 13;
    localparam int          DOUBLE_WORD_PROGRAM_SELECT_POS      = 12;
    localparam int          SER_POS       = 11;
    localparam int          SPR_POS       = 8;
    localparam int          MODULE_SELECT_POS      = 7;
    localparam logic [23:0] PROT_LO       = 24'h0edfb0;
    localparam logic [23:0] PROT_HI       = 24'h0edfbf;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  PREPROG_BYTE  = 8'h00;
    localparam logic [15:0] INVALID_DATA  = 16'h0000;

    typedef enum logic [2:0] {OP_NONE, OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} op_kind_t;
    typedef enum logic [2:0] {PH_IDLE, PH_WORD, PH_DWORD, PH_PREPROG, PH_ERASE,
                              PH_PROT} phase_t;

    typedef struct packed {
        logic              write;
        logic              read;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        be;
        logic [15:0]       wdata;
    } reg_req_t;

    typedef struct packed {
        logic       start;
        logic       halt;
        phase_t     phase;
        logic       module_sel;
        logic [7:0] fill_byte;
    } array_cmd_t;
endpackage

// File: flash_write_op_control.sv
// Purpose: Command register and sequencer for flash program, erase and protection writes
// Assumes: Register port and flash array engine are synchronous to clock
// Notes:   Read data and all outputs appear one cycle after the request
//
// Contract
// - Module select zero targets extension flash, one targets internal flash.
// - Module select clears itself when the write operation ends.
// - Protection set programs zeros over ones from loaded address and data.
// - Protection set with address outside protection window raises sequence error.
// - Protection select bit clears itself at completion.
// - Sector erase sets selected sectors to all ones; software selects one bank.
// - Erase first pre-programs selected sectors to zeros automatically.
// - Sector erase select bit clears itself at completion.
// - Double-word program writes 64 bits at an even-word address.
// - Double-word select bit clears itself at completion.
// - Word program writes 32 bits at the loaded address.
// - Word select bit clears itself at completion.
// - Suspend halts program or erase, returns bank to read, clears busy.
// - In program suspend only reads and program resume are accepted.
// - In erase suspend: reads, erase resume, programs; nested program unsuspendable.
// - Operations begin only when software sets the launch bit.
// - Launch bit clears itself at operation end or suspend.
// - No launch is accepted while the error flag is high.
// - Software writing zero to launch leaves it unchanged.
// - Test block erase is refused outside bootstrap mode; visible only in bootstrap mode.
// - Launch sets the lock; locked registers read invalid, ignore writes except the suspend bit.
// - Only one write operation runs at a time.
module flash_write_op_control
    import flash_op_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  reg_req_t               reg_req,
    input  wire logic              error_flag,
    input  wire logic [ADDR_W-1:0] target_address,
    input  wire logic              test_block_selected,
    input  wire logic              bootstrap_mode,
    input  wire logic              array_done,
    output logic [15:0]            reg_rdata,
    output logic                   read_invalid,
    output logic                   register_lock,
    output logic                   bank_busy,
    output logic                   sequence_error_set,
    output logic                   program_suspended,
    output logic                   erase_suspended,
    output logic                   test_block_visible,
    output array_cmd_t             array_cmd
);
    typedef enum logic [2:0] {S_IDLE, S_PROG_W, S_PROG_D, S_PREPROG, S_ERASE,
                              S_PROT} op_state_t;

    typedef struct packed {
        logic [15:0] cmd;
        op_state_t   st;
        op_state_t   resume_st;
        logic        prog_suspend_bit;
        logic        erase_suspend_bit;
        logic        nested;
        logic        lock;
        logic        busy;
        logic [15:0] rdata;
        logic        rd_invalid;
        logic        seq_err;
        logic        tb_visible;
        array_cmd_t  arr;
    } state_t;

    state_t      q;
    state_t      next_q;
    logic        wr;
    logic [15:0] merged;
    op_kind_t    kind;
    logic        in_range;
    logic        launch_req;
    logic        accept;
    logic        suspend_now;
    logic        finish;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
        merge = old;
        if (be[1]) merge[15:8] = wd[15:8];
        if (be[0]) merge[7:0] = wd[7:0];
    endfunction

    function automatic phase_t phase_of(input op_state_t s);
        case (s)
            S_PROG_W:  phase_of = PH_WORD;
            S_PROG_D:  phase_of = PH_DWORD;
            S_PREPROG: phase_of = PH_PREPROG;
            S_ERASE:   phase_of = PH_ERASE;
            S_PROT:    phase_of = PH_PROT;
            default:   phase_of = PH_IDLE;
        endcase
    endfunction

    function automatic op_state_t first_state(input op_kind_t k);
        case (k)
            OP_WORD:  first_state = S_PROG_W;
            OP_DWORD: first_state = S_PROG_D;
            OP_ERASE: first_state = S_PREPROG;
            OP_PROT:  first_state = S_PROT;
            default:  first_state = S_IDLE;
        endcase
    endfunction

    assign wr     = reg_req.write && (reg_req.addr == CMD_OFFSET);
    assign merged = merge(q.cmd, reg_req.wdata, reg_req.be) & CMD_WRITABLE;

    op_select_decode u_decode (
        .cmd  (merged),
        .kind (kind)
    );

    prot_range_check u_range (
        .addr     (target_address),
        .in_range (in_range)
    );

    // Only a rising write of launch counts; a written zero never clears it
    assign launch_req = wr && merged[LAUNCH_POS] && !q.cmd[LAUNCH_POS];
    // Suspend must be writable while locked, otherwise a running job could never halt
    assign suspend_now = wr && reg_req.be[1] && reg_req.wdata[SUSPEND_BIT_POS] && !q.nested
                         && (q.st inside {S_PROG_W, S_PROG_D, S_PREPROG, S_ERASE})
                         && !array_done;
    assign finish = array_done && (q.st != S_IDLE) && (q.st != S_PREPROG);

    always_comb begin
        next_q            = q;
        next_q.arr.start  = 1'b0;
        next_q.arr.halt   = 1'b0;
        next_q.seq_err    = 1'b0;
        next_q.rd_invalid = 1'b0;
        next_q.tb_visible = bootstrap_mode;
        accept            = 1'b0;
        if (reg_req.read && (reg_req.addr == CMD_OFFSET)) begin
            next_q.rdata      = q.lock ? INVALID_DATA : q.cmd;
            next_q.rd_invalid = q.lock;
        end
        if (wr && !q.lock) begin
            next_q.cmd             = merged;
            next_q.cmd[LAUNCH_POS] = q.cmd[LAUNCH_POS];
        end else if (wr && reg_req.be[1]) begin
            next_q.cmd[SUSPEND_BIT_POS] = reg_req.wdata[SUSPEND_BIT_POS];
        end
        if (q.st == S_IDLE && launch_req && !q.lock && !error_flag
            && !merged[SUSPEND_BIT_POS] && kind != OP_NONE) begin
            if (q.prog_suspend_bit) begin
                // Only the suspended program may restart
                accept = first_state(kind) == q.resume_st;
            end else if (q.erase_suspend_bit) begin
                accept = (kind == OP_ERASE) || (kind == OP_WORD) || (kind == OP_DWORD);
            end else if (kind == OP_ERASE && test_block_selected && !bootstrap_mode) begin
                next_q.seq_err = 1'b1;
            end else if (kind == OP_PROT && !in_range) begin
                next_q.seq_err = 1'b1;
                next_q.cmd     = merged & ~CMD_SEL_MASK & ~16'(1 << LAUNCH_POS);
            end else begin
                accept = 1'b1;
            end
        end
        if (accept) begin
            next_q.cmd[LAUNCH_POS] = 1'b1;
            next_q.lock            = 1'b1;
            next_q.busy            = 1'b1;
            next_q.arr.start       = 1'b1;
            next_q.arr.module_sel  = merged[MODULE_SELECT_POS];
            next_q.st              = first_state(kind);
            if (q.prog_suspend_bit) begin
                next_q.prog_suspend_bit = 1'b0;
            end else if (q.erase_suspend_bit && kind == OP_ERASE) begin
                next_q.erase_suspend_bit = 1'b0;
                next_q.st         = q.resume_st;
            end else if (q.erase_suspend_bit) begin
                next_q.nested = 1'b1;
            end
            next_q.arr.phase     = phase_of(next_q.st);
            next_q.arr.fill_byte = (next_q.st == S_PREPROG) ? PREPROG_BYTE : ERASED_BYTE;
        end
        case (q.st)
            S_IDLE: begin
            end
            S_PREPROG: begin
                if (array_done) begin
                    // Zeros first so every cell erases from the same level
                    next_q.st            = S_ERASE;
                    next_q.arr.start     = 1'b1;
                    next_q.arr.phase     = PH_ERASE;
                    next_q.arr.fill_byte = ERASED_BYTE;
                end
            end
            S_PROG_W, S_PROG_D, S_ERASE, S_PROT: begin
            end
            default: next_q.st = S_IDLE;
        endcase
        if (finish) begin
            next_q.cmd             = next_q.cmd & ~CMD_SEL_MASK;
            next_q.cmd[LAUNCH_POS] = 1'b0;
            next_q.lock            = 1'b0;
            next_q.busy            = 1'b0;
            next_q.nested          = 1'b0;
            next_q.st              = S_IDLE;
            next_q.arr.phase       = PH_IDLE;
        end else if (suspend_now) begin
            next_q.cmd[LAUNCH_POS] = 1'b0;
            next_q.arr.halt        = 1'b1;
            next_q.lock            = 1'b0;
            next_q.busy            = 1'b0;
            next_q.resume_st       = q.st;
            next_q.prog_suspend_bit       = q.st inside {S_PROG_W, S_PROG_D};
            next_q.erase_suspend_bit      = q.st inside {S_PREPROG, S_ERASE};
            next_q.st              = S_IDLE;
            next_q.arr.phase       = PH_IDLE;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q       <= '0;
            q.cmd   <= CMD_RESET;
            q.st    <= S_IDLE;
            q.resume_st <= S_IDLE;
            q.arr.phase <= PH_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata          = q.rdata;
    assign read_invalid       = q.rd_invalid;
    assign register_lock      = q.lock;
    assign bank_busy          = q.busy;
    assign sequence_error_set = q.seq_err;
    assign program_suspended  = q.prog_suspend_bit;
    assign erase_suspended    = q.erase_suspend_bit;
    assign test_block_visible = q.tb_visible;
    assign array_cmd          = q.arr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_accept;
        accept;
    endsequence

    sequence s_finish;
        finish;
    endsequence

    // Halt is a single pulse so the array engine aborts once and then waits for resume
    sequence s_halted;
        q.arr.halt && !q.busy && !q.cmd[LAUNCH_POS] ##1 !q.arr.halt;
    endsequence

    a_launch_by_sw: assert property ($rose(q.cmd[LAUNCH_POS]) |-> $past(launch_req))
        else $error("launch bit rose without a software launch");
    a_launch_clears: assert property (s_finish |=> !q.cmd[LAUNCH_POS] && !q.lock)
        else $error("launch bit not cleared at operation end");
    a_select_clears: assert property (s_finish |=> (q.cmd & CMD_SEL_MASK) == 16'h0000)
        else $error("selection bits not cleared at operation end");
    a_zero_keeps: assert property (q.cmd[LAUNCH_POS] && !array_done && !suspend_now
                                   |=> q.cmd[LAUNCH_POS])
        else $error("launch bit cleared by software");
    a_lock_follows: assert property (q.cmd[LAUNCH_POS] |-> q.lock && q.busy)
        else $error("launch set without lock");
    a_error_blocks: assert property (q.st == S_IDLE && error_flag |=> q.st == S_IDLE)
        else $error("launch accepted with error flag high");
    a_prot_range: assert property (q.st == S_IDLE && launch_req && !q.lock && !error_flag
        && !merged[SUSPEND_BIT_POS] && !q.prog_suspend_bit && !q.erase_suspend_bit && kind == OP_PROT
        && !in_range |=> q.seq_err && q.st == S_IDLE)
        else $error("protection address outside window not flagged");
    a_preprog_first: assert property (q.st == S_PREPROG && array_done
        |=> q.st == S_ERASE && q.arr.start && q.arr.fill_byte == ERASED_BYTE)
        else $error("erase did not follow pre-program");
    a_suspend_bit_halts: assert property (suspend_now |=> s_halted)
        else $error("suspend did not halt the operation");
    a_one_op: assert property (q.st != S_IDLE && q.st != S_PREPROG
        |=> !q.arr.start)
        else $error("second operation started while one runs");
    a_route_module: assert property (s_accept |=> q.arr.module_sel == q.cmd[MODULE_SELECT_POS])
        else $error("module select not routed to the array");
    a_prog_suspend_bit_only: assert property ((q.prog_suspend_bit and s_accept)
        |=> q.st == $past(q.resume_st))
        else $error("other command accepted in program suspend");
endmodule // flash_write_op_control

// File: flash_write_op_control_tb_top.sv
// Purpose: Self-checking bench for the flash write-operation command register
// Assumes: Design assertions sit in the design files; bench drives every port itself
// Notes:   Read answers are checked from a queue of expected words by a separate monitor
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: output mismatch", $time); end end
module flash_write_op_control_tb_top
    import flash_op_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock;
    logic              reset_n;
    reg_req_t          req;
    logic              error_flag;
    logic [ADDR_W-1:0] target_address;
    logic              test_block_selected;
    logic              bootstrap_mode;
    logic              array_done;
    logic [15:0]       reg_rdata;
    logic              read_invalid;
    logic              register_lock;
    logic              bank_busy;
    logic              sequence_error_set;
    logic              program_suspended;
    logic              erase_suspended;
    logic              test_block_visible;
    array_cmd_t        array_cmd;
    int                err_count;
    int                n_checks;
    int                cycles;
    logic [16:0]       exp_q[$];
    logic [16:0]       exp_v;
    logic              rd_seen;
    logic              module_select;
    logic [15:0]       sel [4] = '{16'h2000, 16'h1000, 16'h0800, 16'h0100};
    phase_t            ph [4] = '{PH_WORD, PH_DWORD, PH_PREPROG, PH_PROT};

    flash_write_op_control DUT (
        .clock(clock), .reset_n(reset_n), .reg_req(req), .error_flag(error_flag),
        .target_address(target_address), .test_block_selected(test_block_selected),
        .bootstrap_mode(bootstrap_mode), .array_done(array_done), .reg_rdata(reg_rdata),
        .read_invalid(read_invalid), .register_lock(register_lock), .bank_busy(bank_busy),
        .sequence_error_set(sequence_error_set), .program_suspended(program_suspended),
        .erase_suspended(erase_suspended), .test_block_visible(test_block_visible),
        .array_cmd(array_cmd)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Strobe held one full cycle, then a free edge before the next access
    task automatic wr(input logic [15:0] d, input logic [1:0] be = 2'b11,
                      input logic [23:0] a = CMD_OFFSET);
        @(posedge clock);
        #1;
        req.write = 1'b1;
        req.addr  = a;
        req.be    = be;
        req.wdata = d;
        @(posedge clock);
        #1;
        req.write = 1'b0;
    endtask

    task automatic rd(input logic [16:0] e);
        @(posedge clock);
        #1;
        req.read = 1'b1;
        req.addr = CMD_OFFSET;
        exp_q.push_back(e);
        @(posedge clock);
        #1;
        req.read = 1'b0;
    endtask

    task automatic done1;
        @(posedge clock);
        #1;
        array_done = 1'b1;
        @(posedge clock);
        #1;
        array_done = 1'b0;
    endtask

    task automatic st(input logic lk, input logic by, input logic sa);
        `CHK(register_lock, lk)
        `CHK(bank_busy, by)
        `CHK(array_cmd.start, sa)
    endtask

    // Read answers land at the taking edge and are checked at the next falling edge
    always @(posedge clock) rd_seen <= req.read && (req.addr == CMD_OFFSET);
    always @(negedge clock) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v[15:0])
            `CHK(read_invalid, exp_v[16])
        end
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("ERROR %0t: run did not finish", $time);
            test_done();
        end
    end

    initial begin
        req = '0;
        error_flag = 1'b0;
        target_address = '0;
        test_block_selected = 1'b0;
        bootstrap_mode = 1'b0;
        array_done = 1'b0;
        reset_n = 1'b0;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        void'($urandom(75));
        st(0, 0, 0);
        `CHK(array_cmd.phase, PH_IDLE)
        rd({1'b0, CMD_RESET});
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            module_select = 1'($urandom % 2);
            target_address = PROT_LO + 24'($urandom % 16);
            wr(16'h8000 | sel[i] | {8'h00, module_select, 7'h00});
            st(1, 1, 1);
            `CHK(array_cmd.phase, ph[i])
            `CHK(array_cmd.module_sel, module_select)
            `CHK(array_cmd.fill_byte, (i == 2) ? PREPROG_BYTE : ERASED_BYTE)
            rd({1'b1, INVALID_DATA});
            // Odd passes also try a second launch while the first one runs
            wr(sel[(i + 1) % 4] | {i[0], 15'h0000});
            st(1, 1, 0);
            if (i == 2) begin
                done1();
                st(1, 1, 1);
                `CHK(array_cmd.phase, PH_ERASE)
                `CHK(array_cmd.fill_byte, ERASED_BYTE)
            end
            done1();
            st(0, 0, 0);
            `CHK(array_cmd.phase, PH_IDLE)
            rd({1'b0, 16'h0000});
        end
        $display("test operations done");

        error_flag = 1'b1;
        wr(16'ha000);
        st(0, 0, 0);
        error_flag = 1'b0;
        wr(16'ha800);
        st(0, 0, 0);
        wr(16'h2f7f);
        st(0, 0, 0);
        rd({1'b0, 16'h2f7f & CMD_WRITABLE});
        wr(16'h0000);
        wr(16'ha000, 2'b11, CMD_OFFSET + 24'h000002);
        st(0, 0, 0);
        target_address = PROT_HI + 24'h000001;
        wr(16'h8100);
        `CHK(sequence_error_set, 1'b1)
        st(0, 0, 0);
        rd({1'b0, 16'h0000});
        test_block_selected = 1'b1;
        wr(16'h8800);
        `CHK(sequence_error_set, 1'b1)
        st(0, 0, 0);
        wr(16'h0000);
        bootstrap_mode = 1'b1;
        @(posedge clock);
        #1;
        `CHK(test_block_visible, 1'b1)
        wr(16'h8800);
        st(1, 1, 1);
        done1();
        done1();
        test_block_selected = 1'b0;
        bootstrap_mode = 1'b0;
        $display("test refusals done");

        wr(16'ha000);
        wr(16'h4000, 2'b10);
        `CHK(array_cmd.halt, 1'b1)
        st(0, 0, 0);
        `CHK(program_suspended, 1'b1)
        wr(16'he000);
        st(0, 0, 0);
        wr(16'h0000, 2'b10);
        wr(16'h8800);
        st(0, 0, 0);
        wr(16'ha000);
        st(1, 1, 1);
        `CHK(array_cmd.phase, PH_WORD)
        done1();
        st(0, 0, 0);
        `CHK(program_suspended, 1'b0)
        $display("test program suspend done");

        target_address = PROT_LO;
        wr(16'h8800);
        done1();
        wr(16'h4000, 2'b10);
        `CHK(erase_suspended, 1'b1)
        st(0, 0, 0);
        wr(16'h0000, 2'b10);
        wr(16'h8100);
        st(0, 0, 0);
        wr(16'ha000);
        st(1, 1, 1);
        wr(16'h4000, 2'b10);
        `CHK(array_cmd.halt, 1'b0)
        st(1, 1, 0);
        done1();
        st(0, 0, 0);
        wr(16'h8800);
        st(1, 1, 1);
        `CHK(array_cmd.phase, PH_ERASE)
        done1();
        st(0, 0, 0);
        `CHK(erase_suspended, 1'b0)
        $display("test erase suspend done");
        repeat (2) @(posedge clock);
        test_done();
    end
endmodule // flash_write_op_control_tb_top

// File: op_select_decode.sv
// Purpose: Turns the selection bits of the command word into one operation kind
// Assumes: Exactly one selection bit is valid
// Notes:   Several bits at once give OP_NONE so no launch is taken
module op_select_decode
    import flash_op_pkg::*;
(
    input  wire logic [15:0] cmd,
    output op_kind_t         kind
);
    logic [2:0] count;

    always_comb begin
        count = 3'(cmd[WPG_POS]) + 3'(cmd[DOUBLE_WORD_PROGRAM_SELECT_POS]) + 3'(cmd[SER_POS]) + 3'(cmd[SPR_POS]);
        kind  = OP_NONE;
        if (count == 3'h1) begin
            if (cmd[WPG_POS])       kind = OP_WORD;
            else if (cmd[DOUBLE_WORD_PROGRAM_SELECT_POS]) kind = OP_DWORD;
            else if (cmd[SER_POS])  kind = OP_ERASE;
            else                    kind = OP_PROT;
        end
    end
endmodule // op_select_decode

// File: prot_range_check.sv
// Purpose: Tells whether a target address lies in the protection register window
// Assumes: Address is the full flash address
// Notes:   Pure combinational compare
module prot_range_check
    import flash_op_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    output logic                   in_range
);
    assign in_range = (addr >= PROT_LO) && (addr <= PROT_HI);
endmodule // prot_range_check
